/* File: design/alarm_flags_defs.svh */
`ifndef ALARM_FLAGS_DEFS_SVH
`define ALARM_FLAGS_DEFS_SVH
// Behaviour
// - all masked: every second; seconds-only: per minute
// - seconds, minutes unmasked: alarm once per hour
// - date masked only: alarm once per day
// - nothing masked: full date-time match needed
// - supply monitor trip sets supply-fail flag
// - enabled supply-fail flag drives interrupt low
// - interrupt leads reset by warning interval
// - low battery at power-up clears good flag
// - byte masked when both top bits set
// - compare on update; set flag, interrupt if enabled
// - stable flags read clears flags, releases interrupt
`define ADDR_ALARM_SEC 4'h1
`define ADDR_ALARM_MIN 4'h3
`define ADDR_ALARM_HOUR 4'h5
`define ADDR_ALARM_DATE 4'h7
`define ADDR_INT_ENABLE 4'hC
`define ADDR_FLAGS 4'hD
`define MASK_HIGH_BIT 7
`define MASK_LOW_BIT 6
`define ALARM_RESET 8'h00
// enable register bits
`define BIT_ALARM_IRQ_EN 3
`define BIT_SUPPLY_IRQ_EN 2
// flags register bits
`define BIT_ALARM_HIT 3
`define BIT_SUPPLY_FAIL 2
`define BIT_BATTERY_GOOD 0
// read must hold address this long before clearing
`define FLAGS_HOLD_NS 50
`define CLK_PERIOD_NS 20
`define FLAGS_HOLD_CYC ((`FLAGS_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// warning lead before reset, in microseconds
`define WARN_LEAD_US 100
`define WARN_LEAD_CYC (`WARN_LEAD_US * 1000 / `CLK_PERIOD_NS)
`endif

/* File: design/alarm_flags_pkg.sv */
package alarm_flags_pkg;
  // current time-of-day bytes from the counters
  typedef struct packed {
    logic [7:0] date;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
  } time_s;
  typedef enum logic [1:0] {
    PF_IDLE = 2'b00,
    PF_WARN = 2'b01,
    PF_RESET = 2'b10
  } supply_state_e;
endpackage

/* File: design/alarm_match.sv */
`include "alarm_flags_defs.svh"
module alarm_match
  import alarm_flags_pkg::*;
(
  input wire logic [31:0] compareBytes,
  input wire time_s nowTime,
  output logic hit
);
  // a byte counts when its two mask bits are not both set
  function automatic logic byteOk(input logic [7:0] cmp, input logic [7:0] cur);
    byteOk = (cmp[`MASK_HIGH_BIT] & cmp[`MASK_LOW_BIT]) || (cmp == cur);
  endfunction

  logic [3:0] ok;
  genvar i;
  generate
    for (i = 0; i < 4; i++) begin : g_byte
      assign ok[i] = byteOk(compareBytes[8*i +: 8], nowTime[8*i +: 8]);
    end
  endgenerate
  // all masked gives a hit on every update; masks pick the rate
  assign hit = &ok;
endmodule

/* File: design/alarm_flags.sv */
`include "alarm_flags_defs.svh"
module alarm_flags
  import alarm_flags_pkg::*;
#(
  parameter int WARN_CYC = `WARN_LEAD_CYC
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [7:0] rdData,
  input wire time_s nowTime,
  input wire logic updateTick,
  input wire logic supplyLowPin,
  input wire logic batteryLowPin,
  input wire logic powerUpPulse,
  output logic intOut,
  output logic intOe,
  output logic cpuReset_r
);
  // alarm compare bytes and the two interrupt enables
  logic [7:0] almSec_r, almMin_r, almHour_r, almDate_r;
  logic alarmIrqEn_r, supplyIrqEn_r;

  // event flags and the power-up battery status
  logic alarmHit_r, supplyFail_r, batteryGood_r;
  logic hit, clearFlags, intReq;

  // two-flop synchronisers for the analog pins
  logic [1:0] supplySync_r, battSync_r;

  // flags-read qualifier, interrupt driver and power-fail sequencer
  logic [1:0] holdCnt_r;
  logic intAct_r;
  logic [31:0] warnCnt_r;
  supply_state_e pfState_r;

  // last count of the flags hold and of the warning lead
  localparam logic [1:0] HOLD_LAST = 2'(`FLAGS_HOLD_CYC - 1);
  localparam logic [31:0] WARN_LAST = 32'(WARN_CYC - 1);

  // a flags-register read request, used by the hold counter and the clear
  function automatic logic isFlagsRead(input logic en, input logic [3:0] a);
    isFlagsRead = en && (a == `ADDR_FLAGS);
  endfunction

  // compare bytes run date down to seconds, the same order as the time struct
  alarm_match u_match (
    .compareBytes({almDate_r, almHour_r, almMin_r, almSec_r}),
    .nowTime(nowTime),
    .hit(hit)
  );

  // pins from the analog side go through two flops
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      supplySync_r <= 2'h0;
      battSync_r <= 2'h0;
    end else begin
      supplySync_r <= {supplySync_r[0], supplyLowPin};
      battSync_r <= {battSync_r[0], batteryLowPin};
    end
  end

  // register writes
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      almSec_r <= `ALARM_RESET;
      almMin_r <= `ALARM_RESET;
      almHour_r <= `ALARM_RESET;
      almDate_r <= `ALARM_RESET;
      alarmIrqEn_r <= 1'b0;
      supplyIrqEn_r <= 1'b0;
    end else if (wrEn) begin
      unique case (addr)
        `ADDR_ALARM_SEC: almSec_r <= wrData;
        `ADDR_ALARM_MIN: almMin_r <= wrData;
        `ADDR_ALARM_HOUR: almHour_r <= wrData;
        `ADDR_ALARM_DATE: almDate_r <= wrData;
        `ADDR_INT_ENABLE: begin
          alarmIrqEn_r <= wrData[`BIT_ALARM_IRQ_EN];
          supplyIrqEn_r <= wrData[`BIT_SUPPLY_IRQ_EN];
        end
        default: ;
      endcase
    end
  end

  // count cycles the flags address is held under read; a glitch won't clear
  // the count saturates so a long read clears once, not every cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      holdCnt_r <= 2'h0;
    end else if (isFlagsRead(rdEn, addr)) begin
      if (holdCnt_r != 2'h3) begin
        holdCnt_r <= holdCnt_r + 2'h1;
      end
    end else begin
      holdCnt_r <= 2'h0;
    end
  end
  assign clearFlags = (holdCnt_r == HOLD_LAST) && isFlagsRead(rdEn, addr);

  // event flags: set beats clear in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      alarmHit_r <= 1'b0;
      supplyFail_r <= 1'b0;
    end else begin
      if (updateTick && hit) begin
        alarmHit_r <= 1'b1;
      end else if (clearFlags) begin
        alarmHit_r <= 1'b0;
      end
      // supply flag sets only on leaving idle; a read in the warning clears it for good
      if (supplySync_r[1] && pfState_r == PF_IDLE) begin
        supplyFail_r <= 1'b1;
      end else if (clearFlags) begin
        supplyFail_r <= 1'b0;
      end
    end
  end

  // battery checked only at power-up; status, not an event flag
  // between power-ups the pin is ignored, so a sagging cell cannot flip it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      batteryGood_r <= 1'b1;
    end else if (powerUpPulse) begin
      batteryGood_r <= ~battSync_r[1];
    end
  end

  // warning interval between interrupt and reset
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pfState_r <= PF_IDLE;
      warnCnt_r <= 32'h0;
      cpuReset_r <= 1'b0;
    end else begin
      unique case (pfState_r)
        PF_IDLE: begin
          cpuReset_r <= 1'b0;
          if (supplySync_r[1]) begin
            pfState_r <= PF_WARN;
            warnCnt_r <= 32'h0;
          end
        end
        // a recovery during the lead still runs to reset; the lead is never cut short
        PF_WARN: begin
          if (warnCnt_r == WARN_LAST) begin
            pfState_r <= PF_RESET;
            cpuReset_r <= 1'b1;
          end else begin
            warnCnt_r <= warnCnt_r + 32'h1;
          end
        end
        // reset holds until the synced pin shows the supply back
        PF_RESET: begin
          if (!supplySync_r[1]) begin
            pfState_r <= PF_IDLE;
            cpuReset_r <= 1'b0;
          end
        end
        default: pfState_r <= PF_IDLE;
      endcase
    end
  end

  // request for the pin: any flag whose enable is set
  assign intReq = (alarmHit_r & alarmIrqEn_r) | (supplyFail_r & supplyIrqEn_r);

  // interrupt pin: open drain, driven low while any enabled flag set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      intAct_r <= 1'b0;
    end else begin
      intAct_r <= intReq;
    end
  end
  assign intOe = intAct_r;

  // pin data from its own flop; always low while the enable is high
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      intOut <= 1'b1;
    end else begin
      intOut <= ~intReq;
    end
  end

  // read data registered; unmapped addresses read zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdData <= 8'h00;
    end else begin
      rdData <= 8'h00;
      if (rdEn) begin
        unique case (addr)
          `ADDR_ALARM_SEC: rdData <= almSec_r;
          `ADDR_ALARM_MIN: rdData <= almMin_r;
          `ADDR_ALARM_HOUR: rdData <= almHour_r;
          `ADDR_ALARM_DATE: rdData <= almDate_r;
          `ADDR_INT_ENABLE: begin
            rdData[`BIT_ALARM_IRQ_EN] <= alarmIrqEn_r;
            rdData[`BIT_SUPPLY_IRQ_EN] <= supplyIrqEn_r;
          end
          // the read returns the flags as they stood before the clear lands
          `ADDR_FLAGS: begin
            rdData[`BIT_ALARM_HIT] <= alarmHit_r;
            rdData[`BIT_SUPPLY_FAIL] <= supplyFail_r;
            rdData[`BIT_BATTERY_GOOD] <= batteryGood_r;
          end
          default: ;
        endcase
      end
    end
  end
endmodule

/* File: testbench/alarm_flags_chk.sv */
module alarm_flags_chk #(
  parameter int WARN_CYC = 8
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] addr,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [7:0] rdData,
  input wire logic updateTick,
  input wire logic supplyLowPin,
  input wire logic intOe,
  input wire logic cpuReset_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic flagRd;
  // a flags read as the clear logic sees it
  assign flagRd = rdEn && addr == 4'hD;
  // reset only if the pin was already asserted WARN_CYC cycles before the rise
  property p_lead; $rose(cpuReset_r) |-> $past(supplyLowPin, WARN_CYC); endproperty
  a_lead: assert property (p_lead) else $error("reset without lead");
  property p_wait; $rose(supplyLowPin) && !cpuReset_r |=> !cpuReset_r [*8]; endproperty
  a_wait: assert property (p_wait) else $error("reset too early");
  property p_drop; $fell(supplyLowPin) && cpuReset_r |-> ##[2:4] !cpuReset_r; endproperty
  a_drop: assert property (p_drop) else $error("reset stuck");
  property p_clr;
    (flagRd && !updateTick && !supplyLowPin && !cpuReset_r) [*3] ##1 !updateTick |=> !intOe;
  endproperty
  a_clr: assert property (p_clr) else $error("read left line low");
  // three quiet cycles cover the clear-to-release lag
  property p_hold; (!wrEn && !flagRd) [*3] ##0 intOe |=> intOe; endproperty
  a_hold: assert property (p_hold) else $error("line let go");
  property p_cause;
    $rose(intOe) |-> $past(updateTick, 2) || $past(supplyLowPin, 4) || $past(wrEn, 2);
  endproperty
  a_cause: assert property (p_cause) else $error("line low without event");
  property p_idle; !$past(rdEn) |-> rdData == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("data without read");
  property p_unm; rdEn && addr == 4'h2 |=> rdData == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("hole read nonzero");
  c_alarm: cover property (updateTick ##2 intOe);
  c_warn: cover property ($rose(cpuReset_r));
  c_clr: cover property (flagRd [*3]);
endmodule
bind alarm_flags alarm_flags_chk #(.WARN_CYC(WARN_CYC)) u_chk (
  .clk(clk),
  .reset(reset),
  .addr(addr),
  .wrEn(wrEn),
  .rdEn(rdEn),
  .rdData(rdData),
  .updateTick(updateTick),
  .supplyLowPin(supplyLowPin),
  .intOe(intOe),
  .cpuReset_r(cpuReset_r)
);

/* File: testbench/host_cpu.sv */
module host_cpu (
  input wire logic clk,
  input wire logic [7:0] rdData,
  input wire logic intOut,
  input wire logic intOe,
  output logic intN,
  output logic [3:0] addr,
  output logic [7:0] wrData,
  output logic wrEn,
  output logic rdEn
);
  timeunit 1ns;
  timeprecision 1ns;
  // pull-up holds the line high whenever the device lets go
  assign intN = intOe ? intOut : 1'h1;
  initial {addr, wrData, wrEn, rdEn} = '0;
  // an edge passes after each cycle so no strobe is set twice in one step
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    {addr, wrData, wrEn} = {a, v, 1'h1};
    @(negedge clk);
    wrEn = 1'h0;
    @(negedge clk);
  endtask
  // fewer than three held cycles must leave the flags alone
  task automatic rd(input logic [3:0] a, input int n, output logic [7:0] v);
    {addr, rdEn} = {a, 1'h1};
    @(negedge clk);
    v = rdData;
    repeat (n - 1) @(negedge clk);
    rdEn = 1'h0;
    @(negedge clk);
  endtask
endmodule

/* File: testbench/test_alarm_flags.sv */
module test_alarm_flags
  import alarm_flags_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset, wrEn, rdEn, updateTick, supplyLowPin, batteryLowPin, powerUpPulse;
  logic intOut, intOe, cpuReset_r, intN, e;
  logic [3:0] addr;
  logic [7:0] wrData, rdData, d;
  logic [7:0] al [4];
  time_s nowTime, t;
  int err_total = 0, comparisons = 0;
  alarm_flags #(.WARN_CYC(8)) u_dut (
    .clk(clk),
    .reset(reset),
    .addr(addr),
    .wrData(wrData),
    .wrEn(wrEn),
    .rdEn(rdEn),
    .rdData(rdData),
    .nowTime(nowTime),
    .updateTick(updateTick),
    .supplyLowPin(supplyLowPin),
    .batteryLowPin(batteryLowPin),
    .powerUpPulse(powerUpPulse),
    .intOut(intOut),
    .intOe(intOe),
    .cpuReset_r(cpuReset_r)
  );
  host_cpu u_host (
    .clk(clk),
    .rdData(rdData),
    .intOut(intOut),
    .intOe(intOe),
    .intN(intN),
    .addr(addr),
    .wrData(wrData),
    .wrEn(wrEn),
    .rdEn(rdEn)
  );
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    if (err_total == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // reference model: a byte with both top bits set never blocks the match
  function automatic logic hit(time_s n);
    hit = 1'h1;
    for (int i = 0; i < 4; i++) if (al[i][7:6] != 2'h3 && al[i] != n[8*i +: 8]) hit = 1'h0;
  endfunction
  task automatic tick(time_s n);
    nowTime = n;
    updateTick = 1'h1;
    @(negedge clk);
    updateTick = 1'h0;
    repeat (3) @(negedge clk);
  endtask
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // generous bound, the sequence needs well under a thousand cycles
  initial begin
    #100000;
    err_total++;
    stop_test;
  end
  initial begin
    {reset, updateTick, supplyLowPin, batteryLowPin, powerUpPulse} = 5'h10;
    nowTime = '0;
    void'($urandom(32'h0859));
    repeat (20) @(negedge clk);
    reset = 1'h0;
    u_host.wr(4'hC, 8'h0C);
    u_host.wr(4'h2, 8'hFF);
    u_host.rd(4'h2, 1, d);
    chk(d, 8'h00);
    u_host.rd(4'hC, 1, d);
    chk(d, 8'h0C);
    for (int m = 0; m < 5; m++) begin
      for (int i = 0; i < 4; i++) begin
        al[i] = i < m ? 8'($urandom) & 8'hBF : 8'hC0 | 8'($urandom);
        u_host.wr(4'(2 * i + 1), al[i]);
      end
      for (int i = 0; i < 4; i++) begin
        u_host.rd(4'(2 * i + 1), 1, d);
        chk(d, al[i]);
      end
      for (int k = 0; k < 2; k++) begin
        t = {al[3], al[2], al[1], al[0]} ^ (k == 1 ? 32'h1 << 8 * ($urandom % 4) : 32'h0);
        e = hit(t);
        tick(t);
        chk(intN, !e);
        u_host.rd(4'hD, 2, d);
        chk(d, {4'h0, e, 3'h1});
        u_host.rd(4'hD, 3, d);
        chk(d, {4'h0, e, 3'h1});
        u_host.rd(4'hD, 3, d);
        chk(d, 8'h01);
      end
    end
    // alarm with its enable off: the flag still sets, the line stays released
    u_host.wr(4'hC, 8'h04);
    tick({al[3], al[2], al[1], al[0]});
    chk(intN, 8'h01);
    u_host.rd(4'hD, 3, d);
    chk(d, 8'h09);
    supplyLowPin = 1'h1;
    repeat (5) @(negedge clk);
    chk(intN, 8'h00);
    chk(cpuReset_r, 8'h00);
    repeat (10) @(negedge clk);
    chk(cpuReset_r, 8'h01);
    supplyLowPin = 1'h0;
    repeat (8) @(negedge clk);
    u_host.rd(4'hD, 3, d);
    chk(d, 8'h05);
    batteryLowPin = 1'h1;
    repeat (3) @(negedge clk);
    powerUpPulse = 1'h1;
    @(negedge clk);
    powerUpPulse = 1'h0;
    u_host.rd(4'hD, 3, d);
    chk(d, 8'h00);
    stop_test;
  end
endmodule
